// ==== rtl/fsio_pkg.sv ====
// Constants and types shared by the fieldbus slave I/O connection engine
package fsio_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int ADDR_W   = 6;
  localparam int LEN_W    = 4;
  localparam int DATA_W   = 64;
  localparam int IVL_W    = 16;
  localparam int PRE_W    = 16;

  // Payload limits
  localparam logic [LEN_W-1:0] MAX_LEN  = 4'h8;
  localparam logic [LEN_W-1:0] ZERO_LEN = 4'h0;

  // Input assembly byte 0 layout
  localparam int IN_ON_BIT    = 0;
  localparam int IN_FAULT_BIT = 1;

  // Output assembly byte positions
  localparam int OUT_DISC_LSB = 0;
  localparam int OUT_AUX_LSB  = 8;

  // Values after reset
  localparam logic [7:0]        DOUT_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST  = 64'h0000_0000_0000_0000;
  localparam logic [PRE_W-1:0]  PRE_RST   = 16'h0000;
  localparam logic [IVL_W-1:0]  IVL_RST   = 16'h0000;

  // Message kinds on the receive and transmit sides
  typedef enum logic [2:0] {
    FSIO_NONE   = 3'h0,
    FSIO_POLL   = 3'h1,
    FSIO_STROBE = 3'h2,
    FSIO_REPORT = 3'h3,
    FSIO_ACK    = 3'h4
  } fsio_kind_t;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    FSIO_IDLE = 3'b001,
    FSIO_SEND = 3'b010,
    FSIO_GAP  = 3'b100
  } fsio_state_t;

endpackage

// ==== rtl/fsio_ms_timer.sv ====
// Millisecond interval timer pacing periodic reports and heartbeats
module fsio_ms_timer
  import fsio_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // Control
  input  wire logic             enable,
  input  wire logic             restart,
  input  wire logic [IVL_W-1:0] interval,
  // Event
  output logic                  expire_q
);

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYC - 1);

  logic [PRE_W-1:0] pre_q;   // Cycles within current millisecond
  logic [IVL_W-1:0] ms_q;    // Whole milliseconds elapsed
  logic             ms_tick; // Last cycle of a millisecond
  logic             ms_done; // Interval reached

  assign ms_tick = (pre_q == PRE_LAST);
  assign ms_done = ms_tick && (ms_q == interval - 16'h0001);

  // Prescaler and interval counter; zero interval disables the timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= PRE_RST;
      ms_q  <= IVL_RST;
    end else if (ce) begin
      if (!enable || restart || interval == IVL_RST) begin
        pre_q <= PRE_RST;
        ms_q  <= IVL_RST;
      end else if (ms_done) begin
        pre_q <= PRE_RST;
        ms_q  <= IVL_RST;
      end else if (ms_tick) begin
        pre_q <= PRE_RST;
        ms_q  <= ms_q + 16'h0001;
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      expire_q <= 1'b0;
    end else if (ce) begin
      expire_q <= enable && !restart && interval != IVL_RST && ms_done;
    end
  end

endmodule

// ==== rtl/fsio_slave.sv ====
// Slave I/O connection engine: poll, strobe and report messaging
module fsio_slave
  import fsio_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // Configuration
  input  wire logic [ADDR_W-1:0] node_address,
  input  wire logic [ADDR_W-1:0] master_address,
  input  wire logic              poll_enable,
  input  wire logic              strobe_enable,
  input  wire logic              report_enable,
  input  wire logic              input_change_triggered,
  input  wire logic              report_to_slave,
  input  wire logic              ack_enable,
  input  wire logic [IVL_W-1:0]  packet_interval,
  input  wire logic [LEN_W-1:0]  input_length,
  // Received message from the controller
  input  wire logic              rx_valid,
  input  wire fsio_kind_t        rx_kind,
  input  wire logic [ADDR_W-1:0] rx_src,
  input  wire logic [LEN_W-1:0]  rx_len,
  input  wire logic [DATA_W-1:0] rx_data,
  // Message to transmit
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output fsio_kind_t             tx_kind,
  output logic [LEN_W-1:0]       tx_len,
  output logic [DATA_W-1:0]      tx_data,
  // Device attributes
  input  wire logic              sense_on,
  input  wire logic              sense_fault,
  input  wire logic [55:0]       input_attr,
  output logic [7:0]             discrete_out,
  output logic [7:0]             aux_out,
  output logic                   strobe_bit,
  output logic                   measure_trig,
  // Status
  input  wire logic              ack_timeout_clr,
  output logic                   ack_timeout,
  output logic                   config_error
);

  fsio_state_t       state_q;       // Transmit sequencer
  logic              poll_pend_q;   // Poll response owed
  logic              strb_pend_q;   // Strobe response owed
  logic              ack_pend_q;    // Acknowledge owed to master
  logic              rep_pend_q;    // Input report owed
  logic              ack_wait_q;    // Awaiting master acknowledge
  logic [DATA_W-1:0] last_sent_q;   // Last reported input assembly
  logic              tx_valid_q;
  fsio_kind_t        tx_kind_q;
  logic [LEN_W-1:0]  tx_len_q;
  logic [DATA_W-1:0] tx_data_q;
  logic [7:0]        dout_q;
  logic [7:0]        aux_q;
  logic              sbit_q;
  logic              trig_q;
  logic              ack_to_q;
  logic              cfg_err_q;

  logic              from_master;   // Message from own master
  logic              poll_ok;       // Poll connection may run
  logic              rep_in;        // Slave-to-master reporting
  logic              rep_out;       // Master-to-slave reporting
  logic              take_poll;
  logic              take_strb;
  logic              take_ack;
  logic              take_rep;
  logic              idle_take;
  logic              poll_rx;
  logic              strb_rx;
  logic              out_rx;        // Output data from master
  logic              ack_rx;
  logic              chg_det;
  logic              tmr_exp;
  logic              tmr_restart;
  logic [DATA_W-1:0] in_asm;        // Gathered input assembly
  logic [LEN_W-1:0]  in_len;        // Clamped input length

  // Connection set: single report connection, poll excluded with master-to-slave reporting
  assign rep_in  = report_enable && !report_to_slave;
  assign rep_out = report_enable && report_to_slave;
  assign poll_ok = poll_enable && !rep_out;

  // Only the master's traffic is taken
  assign from_master = ce && rx_valid && (rx_src == master_address);
  assign poll_rx = from_master && rx_kind == FSIO_POLL && poll_ok;
  assign out_rx  = from_master && rx_kind == FSIO_POLL && rep_out;
  assign strb_rx = from_master && rx_kind == FSIO_STROBE
                   && strobe_enable;
  assign ack_rx  = from_master && rx_kind == FSIO_ACK;

  // Input assembly: presence byte then further attributes
  always_comb begin
    in_asm = {input_attr, 8'h00};
    in_asm[IN_ON_BIT]    = sense_on;
    in_asm[IN_FAULT_BIT] = sense_fault;
  end

  // Payload never exceeds eight bytes
  assign in_len = (input_length > MAX_LEN) ? MAX_LEN : input_length;

  // Change detection against what was last reported
  assign chg_det = rep_in && input_change_triggered
                   && (in_asm != last_sent_q);

  // Transmit priority: poll, strobe, acknowledge, report
  assign idle_take = ce && state_q == FSIO_IDLE;
  assign take_poll = idle_take && poll_pend_q;
  assign take_strb = idle_take && !poll_pend_q && strb_pend_q;
  assign take_ack  = idle_take && !poll_pend_q && !strb_pend_q && ack_pend_q;
  assign take_rep  = idle_take && !poll_pend_q && !strb_pend_q
                     && !ack_pend_q && rep_pend_q;

  // Heartbeat restarts after each report in change mode
  assign tmr_restart = take_rep && input_change_triggered;

  fsio_ms_timer #(
    .MS_CYC   (MS_CYC)
  ) u_timer (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .enable   (rep_in),
    .restart  (tmr_restart),
    .interval (packet_interval),
    .expire_q (tmr_exp)
  );

  // Pending responses; a new request wins over a clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_pend_q <= 1'b0;
      strb_pend_q <= 1'b0;
      ack_pend_q  <= 1'b0;
      rep_pend_q  <= 1'b0;
    end else if (ce) begin
      poll_pend_q <= (poll_pend_q && !take_poll) || poll_rx;
      strb_pend_q <= (strb_pend_q && !take_strb) || strb_rx;
      ack_pend_q  <= (ack_pend_q && !take_ack)
                     || (out_rx && ack_enable);
      // A change seen on the loading edge is already in that report
      rep_pend_q  <= ((rep_pend_q && !take_rep) || tmr_exp
                      || (chg_det && !take_rep))
                     && rep_in;
    end
  end

  // Transmit sequencer with valid/ready hold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= FSIO_IDLE;
      tx_valid_q <= 1'b0;
      tx_kind_q  <= FSIO_NONE;
      tx_len_q   <= ZERO_LEN;
      tx_data_q  <= DATA_RST;
    end else if (ce) begin
      case (state_q)
        FSIO_IDLE: begin
          if (take_poll || take_strb || take_rep) begin
            // Individual response carrying the input assembly
            state_q    <= FSIO_SEND;
            tx_valid_q <= 1'b1;
            tx_len_q   <= in_len;
            tx_data_q  <= in_asm;
            if (take_poll) begin
              tx_kind_q <= FSIO_POLL;
            end else if (take_strb) begin
              tx_kind_q <= FSIO_STROBE;
            end else begin
              tx_kind_q <= FSIO_REPORT;
            end
          end else if (take_ack) begin
            // Data-free acknowledge of master output
            state_q    <= FSIO_SEND;
            tx_valid_q <= 1'b1;
            tx_kind_q  <= FSIO_ACK;
            tx_len_q   <= ZERO_LEN;
            tx_data_q  <= DATA_RST;
          end
        end
        FSIO_SEND: begin
          if (tx_ready) begin
            state_q    <= FSIO_GAP;
            tx_valid_q <= 1'b0;
          end
        end
        FSIO_GAP: begin
          state_q <= FSIO_IDLE;
        end
        default: begin
          state_q    <= FSIO_IDLE;
          tx_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Reported assembly snapshot for change detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_sent_q <= DATA_RST;
    end else if (ce && take_rep) begin
      last_sent_q <= in_asm;
    end
  end

  // Acknowledge tracking on slave reports
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_wait_q <= 1'b0;
      ack_to_q   <= 1'b0;
    end else if (ce) begin
      if (take_rep) begin
        ack_wait_q <= ack_enable;
      end else if (ack_rx || !ack_enable || tmr_exp) begin
        ack_wait_q <= 1'b0;
      end
      // Missing acknowledge by next interval; set wins over clear
      ack_to_q <= (ack_to_q && !ack_timeout_clr)
                  || (ack_wait_q && ack_enable && tmr_exp && !ack_rx);
    end
  end

  // Output assembly: scatter received bytes into attributes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_q <= DOUT_RST;
      aux_q  <= DOUT_RST;
    end else if (ce && (poll_rx || out_rx)) begin
      if (rx_len > ZERO_LEN) begin
        dout_q <= rx_data[OUT_DISC_LSB +: 8];
      end
      if (rx_len > 4'h1) begin
        aux_q <= rx_data[OUT_AUX_LSB +: 8];
      end
    end
  end

  // Strobe bit select and measurement trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sbit_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (ce) begin
      trig_q <= strb_rx;
      if (strb_rx) begin
        sbit_q <= rx_data[node_address];
      end
    end
  end

  // Poll configured together with master-to-slave reporting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_err_q <= 1'b0;
    end else if (ce) begin
      cfg_err_q <= poll_enable && rep_out;
    end
  end

  // Outputs straight from flip-flops
  assign tx_valid     = tx_valid_q;
  assign tx_kind      = tx_kind_q;
  assign tx_len       = tx_len_q;
  assign tx_data      = tx_data_q;
  assign discrete_out = dout_q;
  assign aux_out      = aux_q;
  assign strobe_bit   = sbit_q;
  assign measure_trig = trig_q;
  assign ack_timeout  = ack_to_q;
  assign config_error = cfg_err_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence load_s;
    idle_take && (take_poll || take_strb || take_rep);
  endsequence

  sequence stall_s;
    tx_valid && !tx_ready && ce;
  endsequence

  foreign_drop_a: assert property (
    (ce && rx_valid && rx_src != master_address) |=> !measure_trig)
    else $error("Foreign message triggered a strobe");

  poll_pend_a: assert property (
    poll_rx |=> poll_pend_q)
    else $error("Poll command not answered");

  strobe_bit_a: assert property (
    strb_rx |=> strobe_bit == $past(rx_data[node_address]) && measure_trig)
    else $error("Wrong strobe bit selected");

  strobe_rsp_a: assert property (
    strb_rx |=> strb_pend_q)
    else $error("Strobe response not queued");

  rsp_len_a: assert property (
    tx_valid |-> tx_len <= MAX_LEN)
    else $error("Response longer than eight bytes");

  periodic_a: assert property (
    (ce && tmr_exp && rep_in) |=> rep_pend_q || tx_kind == FSIO_REPORT)
    else $error("Periodic report missed");

  change_rep_a: assert property (
    (ce && chg_det) |=> rep_pend_q || tx_kind == FSIO_REPORT)
    else $error("Input change not reported");

  out_ack_a: assert property (
    (out_rx && ack_enable) |=> ack_pend_q)
    else $error("Acknowledge not queued");

  no_ack_wait_a: assert property (
    (take_rep && !ack_enable) |=> !ack_wait_q)
    else $error("Acknowledge expected while suppressed");

  poll_excl_a: assert property (
    (from_master && rx_kind == FSIO_POLL && rep_out) |=> !$rose(poll_pend_q))
    else $error("Poll taken with master-to-slave reporting");

  out_asm_a: assert property (
    ((poll_rx || out_rx) && rx_len > ZERO_LEN)
      |=> discrete_out == $past(rx_data[7:0]))
    else $error("Output assembly not applied");

  in_asm_a: assert property (
    load_s |=> tx_data[7:0] == {6'h00, $past(sense_fault), $past(sense_on)})
    else $error("Input assembly byte wrong");

  tx_hold_a: assert property (
    stall_s |=> tx_valid && $stable(tx_data) && $stable(tx_kind))
    else $error("Transmit dropped before ready");

endmodule

// ==== dv/fsio_master_model.sv ====
// Bus master controller model: issues decoded messages and takes replies
module fsio_master_model
  import fsio_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Messages towards the slave
  output logic                   rx_valid,
  output fsio_kind_t             rx_kind,
  output logic [ADDR_W-1:0]      rx_src,
  output logic [LEN_W-1:0]       rx_len,
  output logic [DATA_W-1:0]      rx_data,
  // Replies from the slave
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire fsio_kind_t        tx_kind,
  input  wire logic [LEN_W-1:0]  tx_len,
  input  wire logic [DATA_W-1:0] tx_data,
  // Cycles of stall before a reply is taken
  input  wire logic [3:0]        stall
);
  timeunit 1ns;
  timeprecision 100ps;

  // Replies taken, with the time of taking
  fsio_kind_t        q_kind[$];
  logic [LEN_W-1:0]  q_len[$];
  logic [DATA_W-1:0] q_data[$];
  time               q_time[$];
  int                cnt;
  logic              taken;

  // Idle values at time zero
  initial begin
    rx_valid = 1'b0;
    rx_kind  = FSIO_NONE;
    rx_src   = '0;
    rx_len   = '0;
    rx_data  = '0;
    tx_ready = 1'b0;
    cnt      = 0;
  end

  // One message as a single-cycle pulse; idle lines then show garbage
  task automatic send(input fsio_kind_t k, input logic [ADDR_W-1:0] src,
                      input logic [LEN_W-1:0] len,
                      input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_kind  = k;
    rx_src   = src;
    rx_len   = len;
    rx_data  = d;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_kind  = FSIO_NONE;
    rx_src   = ~src;
    rx_data  = ~d;
  endtask

  // Take a reply after the set stall, ready held until taken
  always @(posedge clk) begin
    taken = tx_valid && tx_ready && reset_n;
    if (taken) begin
      q_kind.push_back(tx_kind);
      q_len.push_back(tx_len);
      q_data.push_back(tx_data);
      q_time.push_back($time);
    end
    #1;
    if (!reset_n || taken) begin
      tx_ready = 1'b0;
      cnt      = 0;
    end else if (tx_valid && cnt >= int'(stall)) begin
      tx_ready = 1'b1;
    end else if (tx_valid) begin
      cnt++;
    end
  end
endmodule

// ==== dv/test_fsio_slave.sv ====
// Self-checking bench for the slave I/O connection engine
module test_fsio_slave
  import fsio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Short millisecond for simulation; report interval in ns
  localparam int SIM_MS = 10;
  localparam int IVL_NS = 2 * SIM_MS * 100;

  logic              clk, reset_n, ce, poll_enable, strobe_enable;
  logic              report_enable, input_change_triggered, report_to_slave;
  logic              ack_enable, rx_valid, tx_valid, tx_ready, sense_on;
  logic              sense_fault, strobe_bit, measure_trig, ack_timeout_clr;
  logic              ack_timeout, config_error;
  logic [ADDR_W-1:0] node_address, master_address, rx_src;
  logic [IVL_W-1:0]  packet_interval;
  logic [LEN_W-1:0]  input_length, rx_len, tx_len;
  logic [DATA_W-1:0] rx_data, tx_data, pat;
  logic [55:0]       input_attr;
  logic [7:0]        discrete_out, aux_out;
  logic [3:0]        stall;
  fsio_kind_t        rx_kind, tx_kind;
  time               last_t, t1;
  int                n_fail, n_tests;

  // Design under test with a short millisecond
  fsio_slave #(.MS_CYC(SIM_MS)) i_dut (
    .clk, .reset_n, .ce, .node_address, .master_address, .poll_enable,
    .strobe_enable, .report_enable, .input_change_triggered,
    .report_to_slave, .ack_enable, .packet_interval, .input_length,
    .rx_valid, .rx_kind, .rx_src, .rx_len, .rx_data, .tx_valid, .tx_ready,
    .tx_kind, .tx_len, .tx_data, .sense_on, .sense_fault, .input_attr,
    .discrete_out, .aux_out, .strobe_bit, .measure_trig, .ack_timeout_clr,
    .ack_timeout, .config_error
  );

  // Controller on the far side
  fsio_master_model i_master (
    .clk, .reset_n, .rx_valid, .rx_kind, .rx_src, .rx_len, .rx_data,
    .tx_valid, .tx_ready, .tx_kind, .tx_len, .tx_data, .stall
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Step just past each of the next n rising edges
  task automatic settle(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Expected input assembly and its clamped length
  function automatic logic [63:0] asm_exp();
    return {input_attr, 6'h00, sense_fault, sense_on};
  endfunction

  function automatic logic [LEN_W-1:0] exp_len();
    return (input_length > MAX_LEN) ? MAX_LEN : input_length;
  endfunction

  // Let traffic run out, then forget it
  task automatic flush(input int n);
    settle(n);
    i_master.q_kind.delete();
    i_master.q_len.delete();
    i_master.q_data.delete();
    i_master.q_time.delete();
  endtask

  // Nothing may be sent for n cycles
  task automatic no_tx(input int n);
    settle(n);
    check(64'(i_master.q_kind.size()), 64'h0);
  endtask

  // Wait for one reply and compare its meaningful bytes
  task automatic get_tx(input fsio_kind_t k, input logic [LEN_W-1:0] l);
    int          n;
    logic [63:0] m;
    n = 0;
    m = (l >= MAX_LEN) ? '1 : ((64'h1 << (8 * l)) - 64'h1);
    // Step past each edge so callers never drive on the sampling edge
    while (i_master.q_kind.size() == 0 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(64'(i_master.q_kind.size() != 0), 64'h1);
    if (i_master.q_kind.size() != 0) begin
      check(i_master.q_kind.pop_front(), k);
      check(i_master.q_len.pop_front(), l);
      check(i_master.q_data.pop_front() & m, asm_exp() & m);
      last_t = i_master.q_time.pop_front();
    end
  endtask

  // Watchdog against a hang
  initial begin
    #500000;
    n_fail++;
    $display("ERROR %0t: run did not finish", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    {ce, poll_enable, strobe_enable, report_enable} = 4'h8;
    {input_change_triggered, report_to_slave, ack_enable} = 3'h0;
    {sense_on, sense_fault, ack_timeout_clr} = 3'h4;
    node_address = 6'h05;
    master_address = 6'h01;
    packet_interval = 16'h0002;
    input_length = 4'h3;
    input_attr = 56'h11_2233_4455_6677;
    stall = 4'h2;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    // Polled exchange with a slow controller
    poll_enable = 1'b1;
    i_master.send(FSIO_POLL, 6'h01, 4'h2, 64'hA53C);
    settle(1);
    check(discrete_out, 8'h3C);
    check(aux_out, 8'hA5);
    get_tx(FSIO_POLL, exp_len());
    // Frozen clock enable, then a foreign source
    ce = 1'b0;
    i_master.send(FSIO_POLL, 6'h01, 4'h1, 64'h77);
    ce = 1'b1;
    i_master.send(FSIO_POLL, 6'h02, 4'h1, 64'h77);
    no_tx(10);
    check(discrete_out, 8'h3C);
    // Strobes with own bit set then clear, empty and clamped length
    {poll_enable, strobe_enable, stall} = 6'h10;
    for (int i = 0; i < 2; i++) begin
      input_length = i ? 4'hF : 4'h0;
      pat = i ? 64'hFFFF_FFFF_FFFF_FFDF : 64'h20;
      // Bit and trigger show in the cycle right after the strobe
      i_master.send(FSIO_STROBE, 6'h01, 4'h8, pat);
      check(strobe_bit, pat[5]);
      check(measure_trig, 1'b1);
      settle(1);
      check(measure_trig, 1'b0);
      get_tx(FSIO_STROBE, exp_len());
    end
    // Periodic reports
    {strobe_enable, report_enable, input_length} = 6'h12;
    flush(25);
    get_tx(FSIO_REPORT, exp_len());
    t1 = last_t;
    get_tx(FSIO_REPORT, exp_len());
    check(last_t - t1, 64'(IVL_NS));
    // Missing acknowledge, then acknowledged reports
    ack_enable = 1'b1;
    get_tx(FSIO_REPORT, exp_len());
    get_tx(FSIO_REPORT, exp_len());
    settle(3);
    check(ack_timeout, 1'b1);
    for (int i = 0; i < 3; i++) begin
      get_tx(FSIO_REPORT, exp_len());
      i_master.send(FSIO_ACK, 6'h01, 4'h0, 64'h0);
      ack_timeout_clr = (i == 0);
      settle(1);
      ack_timeout_clr = 1'b0;
    end
    settle(3);
    check(ack_timeout, 1'b0);
    // Suppressed acknowledges are not awaited
    ack_enable = 1'b0;
    get_tx(FSIO_REPORT, exp_len());
    get_tx(FSIO_REPORT, exp_len());
    settle(3);
    check(ack_timeout, 1'b0);
    // Change-triggered report and restarted heartbeat
    input_change_triggered = 1'b1;
    flush(30);
    // Change lands late in the interval, about four cycles before the next heartbeat
    settle(2);
    sense_on = 1'b0;
    t1 = $time;
    get_tx(FSIO_REPORT, exp_len());
    check(64'(last_t - t1 <= 500), 64'h1);
    t1 = last_t;
    get_tx(FSIO_REPORT, exp_len());
    check(64'(last_t - t1 >= IVL_NS && last_t - t1 <= IVL_NS + 300),
          64'h1);
    // Output reporting towards the slave refuses polling
    {poll_enable, report_to_slave, ack_enable} = 3'h7;
    flush(25);
    check(config_error, 1'b1);
    i_master.send(FSIO_POLL, 6'h01, 4'h1, 64'h665A);
    settle(1);
    check(discrete_out, 8'h5A);
    check(aux_out, 8'hA5);
    get_tx(FSIO_ACK, 4'h0);
    no_tx(10);
    complete_run();
  end
endmodule
